// ---- hw/crt_decode.sv ----
// Coprocessor register-transfer and undefined-instruction decoder with AXI4-Lite control.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - Execute only when the condition field passes the current flags, otherwise no-op.
// - Transfer to pc_register loads word bits 31..28 into N, Z, C, V.
// - Such transfer ignores other bits; pc and other status bits unchanged.
// - Transfer from pc_register sends instruction address plus twelve.
// - Move from coprocessor costs 1S plus (b+1)I plus 1C.
// - Move to coprocessor costs 1S plus bI plus 1C.
// - Direction bit one moves coprocessor to core, zero core to coprocessor.
// - Coprocessor number field selects which coprocessor acts.
// - Passing undefined-class encoding enters the undefined-instruction exception.
// - Undefined exception costs 2S plus 1I plus 1N cycles.
// - With no coprocessor fitted every coprocessor instruction traps as undefined.
module crt_decode
  import crt_pkg::*;
#(
  parameter bit CP_FITTED = 1'b0
) (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output crt_cp_req_t      CP_REQ,
  input  wire crt_cp_ack_t CP_ACK,
  output logic             IRQ
);

  // Software-visible state, then the engine's internal state and counters.
  logic [31:0]       instr_q, addr_q, core_q, result_q, cycles_q;
  logic [3:0]        flags_q;
  logic [IRQ_W-1:0]  irq_st_q, irq_msk_q;
  logic              und_q, skip_q, busy_q;
  crt_state_t        state_q;
  logic [31:0]       cnt_q;
  logic [3:0]        seq_q;

  // AXI write side: capture address and data in either order.
  logic              aw_have_q, w_have_q;
  logic [7:0]        aw_q;
  logic [31:0]       wd_q;
  logic [3:0]        ws_q;
  wire  logic        wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
  wire  logic [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire  logic        wr_instr = wr_fire && (aw_q == OFF_INSTR) && !busy_q;
  wire  logic        wr_known = (aw_q <= OFF_CYCLES) && (aw_q[1:0] == 2'h0);

  // Condition evaluation against N, Z, C, V.
  wire  logic        fn = flags_q[3];
  wire  logic        fz = flags_q[2];
  wire  logic        fc = flags_q[1];
  wire  logic        fv = flags_q[0];
  wire  logic [3:0]  cond = instr_q[COND_HI:COND_LO];
  logic              cond_base, cond_pass;
  always_comb begin
    case (cond[3:1])
      3'h0:    cond_base = fz;
      3'h1:    cond_base = fc;
      3'h2:    cond_base = fn;
      3'h3:    cond_base = fv;
      3'h4:    cond_base = fc && !fz;
      3'h5:    cond_base = (fn == fv);
      3'h6:    cond_base = !fz && (fn == fv);
      default: cond_base = 1'b1;
    endcase
    cond_pass = (cond == COND_AL) ? 1'b1 : (cond_base ^ cond[0]);
  end

  // Instruction class decode.
  wire  logic        is_rt  = (instr_q[27:24] == RT_CLASS) && instr_q[4];
  wire  logic        is_und = (instr_q[27:25] == UND_CLASS) && instr_q[4];
  wire  logic        is_cp  = (instr_q[27:26] == 2'h3) && !is_rt;
  wire  logic        dir_from_cp = instr_q[DIR_BIT];
  wire  logic        rd_is_pc = (instr_q[RD_HI:RD_LO] == PC_REG);
  // A transfer from pc_register ships the instruction address plus twelve.
  wire  logic [31:0] mcr_data = rd_is_pc ? addr_q + PC_OFFSET : core_q;
  // Rejection: no unit claims the offered instruction, or none is fitted at all.
  wire  logic        cp_reject = !CP_FITTED || CP_ACK.absent;
  // Anything outside the three classes retires at once so that busy cannot stick.
  wire  logic        not_ours = !(is_und || is_cp || is_rt);

  // Next state and cost bookkeeping.
  crt_state_t        state_d;
  logic              fire;
  always_comb begin
    state_d = state_q;
    fire    = 1'b0;
    case (state_q)
      CRT_IDLE: if (busy_q) begin
        if (!cond_pass) begin
          state_d = CRT_IDLE;
        end else if (is_und || is_cp || (is_rt && !CP_FITTED)) begin
          state_d = CRT_SEQ;
        end else if (is_rt) begin
          state_d = CRT_BUSY;
        end
      end
      CRT_SEQ:   state_d = (seq_q == UND_S_CYC - 4'h1) ? CRT_UND_I : CRT_SEQ;
      CRT_UND_I: state_d = CRT_UND_N;
      CRT_UND_N: state_d = CRT_IDLE;
      // Absent only means something once the instruction is on offer, so it is judged here.
      CRT_BUSY: if (cp_reject) begin
        state_d = CRT_SEQ;
      end else if (!CP_ACK.busy) begin
        state_d = dir_from_cp ? CRT_INT : CRT_XFER;
      end
      CRT_INT:  state_d = CRT_XFER;
      CRT_XFER: begin
        state_d = CRT_IDLE;
        fire    = 1'b1;
      end
      default:  state_d = CRT_IDLE;
    endcase
  end

  // Execution engine; the issue cycle is the register write landing and is not charged.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q  <= CRT_IDLE;
      cnt_q    <= 32'h00000000;
      seq_q    <= 4'h0;
      busy_q   <= 1'b0;
      und_q    <= 1'b0;
      skip_q   <= 1'b0;
      result_q <= 32'h00000000;
      cycles_q <= 32'h00000000;
      CP_REQ   <= '0;
    end else begin
      state_q <= state_d;
      // A refused offer has already spent its busy cycle as the first sequential one.
      seq_q   <= (state_q == CRT_SEQ) ? seq_q + 4'h1 : ((state_q == CRT_BUSY) ? 4'h1 : 4'h0);
      if (state_q == CRT_IDLE && busy_q) begin
        cnt_q  <= 32'h00000000;
        skip_q <= !cond_pass;
        und_q  <= 1'b0;
        if (cond_pass && is_rt && CP_FITTED) begin
          // Opcode, info and register fields go out untouched.
          CP_REQ.offer <= 1'b1;
          CP_REQ.instr <= instr_q;
          CP_REQ.wdata <= mcr_data;
        end
      end else if (state_q != CRT_IDLE) begin
        cnt_q <= cnt_q + 32'h00000001;
      end
      if (state_q == CRT_XFER || (state_q == CRT_BUSY && cp_reject)) begin
        CP_REQ.offer <= 1'b0;
      end
      if (state_q == CRT_XFER && dir_from_cp && !rd_is_pc) begin
        result_q <= CP_ACK.rdata;
      end
      if (state_q == CRT_UND_N) begin
        und_q <= 1'b1;
      end
      if (busy_q && state_d == CRT_IDLE && state_q != CRT_IDLE) begin
        busy_q   <= 1'b0;
        cycles_q <= cnt_q + 32'h00000001;
      end else if (busy_q && state_q == CRT_IDLE && (!cond_pass || not_ours)) begin
        busy_q   <= 1'b0;
        cycles_q <= 32'h00000000;
      end else if (wr_instr) begin
        busy_q <= 1'b1;
      end
    end
  end

  // Flags: a transfer to pc_register loads only N, Z, C, V from the word.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_q <= 4'h0;
    end else if (fire && dir_from_cp && rd_is_pc) begin
      flags_q <= CP_ACK.rdata[FLAG_N_BIT:FLAG_V_BIT];
    end else if (wr_fire && aw_q == OFF_FLAGS && !busy_q) begin
      flags_q <= wd_q[3:0];
    end
  end

  // Interrupt status: sticky, write one to clear, a new event wins.
  wire  logic [IRQ_W-1:0] ev = {busy_q && state_q == CRT_IDLE && !cond_pass,
                                state_q == CRT_UND_N,
                                fire};
  wire  logic [IRQ_W-1:0] clr = (wr_fire && aw_q == OFF_IRQ_ST) ? wd_q[IRQ_W-1:0]
                                                                 : '0;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_st_q  <= '0;
      irq_msk_q <= '0;
      IRQ       <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~clr) | ev;
      if (wr_fire && aw_q == OFF_IRQ_MSK) begin
        irq_msk_q <= wd_q[IRQ_W-1:0];
      end
      IRQ <= |(((irq_st_q & ~clr) | ev) & irq_msk_q);
    end
  end

  // Plain registers written by software.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      instr_q <= 32'h00000000;
      addr_q  <= 32'h00000000;
      core_q  <= 32'h00000000;
    end else if (wr_fire && !busy_q) begin
      if (aw_q == OFF_INSTR) instr_q <= (instr_q & ~wmask) | (wd_q & wmask);
      if (aw_q == OFF_ADDR)  addr_q  <= (addr_q & ~wmask) | (wd_q & wmask);
      if (aw_q == OFF_CORE)  core_q  <= (core_q & ~wmask) | (wd_q & wmask);
    end
  end

  // AXI write channel handshakes; writes to the instruction, address, core or flags register while busy are answered SLVERR.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= 8'h00;
      wd_q          <= 32'h00000000;
      ws_q          <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q     <= 1'b1;
        aw_q          <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q     <= 1'b1;
        wd_q         <= S_AXI_WDATA;
        ws_q         <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_known && !(busy_q && aw_q <= OFF_FLAGS)) ? RESP_OKAY
                                                                     : RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Read mux.
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      OFF_INSTR:   rd_mux = instr_q;
      OFF_ADDR:    rd_mux = addr_q;
      OFF_CORE:    rd_mux = core_q;
      OFF_FLAGS:   rd_mux = {28'h0000000, flags_q};
      OFF_RESULT:  rd_mux = result_q;
      OFF_STATUS:  rd_mux = {29'h00000000, skip_q, und_q, busy_q};
      OFF_IRQ_ST:  rd_mux = {29'h00000000, irq_st_q};
      OFF_IRQ_MSK: rd_mux = {29'h00000000, irq_msk_q};
      OFF_CYCLES:  rd_mux = cycles_q;
      default: begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // AXI read channel: one-cycle answer after the address is taken.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_mux;
      S_AXI_RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Checks.
  sequence s_und_tail;
    (state_q == CRT_UND_I) ##1 (state_q == CRT_UND_N) ##1 (state_q == CRT_IDLE);
  endsequence

  a_cond_fail_noop: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_q == CRT_IDLE && busy_q && !cond_pass) |=> (state_q == CRT_IDLE && !CP_REQ.offer))
    else $error("Failed condition did not act as a no-op.");
  a_flag_load: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (fire && dir_from_cp && rd_is_pc) |=> (flags_q == $past(CP_ACK.rdata[31:28])))
    else $error("Flags not loaded from transferred word.");
  a_pc_result_kept: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (fire && rd_is_pc) |=> $stable(result_q))
    else $error("Transfer to pc changed the result register.");
  a_pc_plus_twelve: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ($rose(CP_REQ.offer) && !CP_REQ.instr[DIR_BIT] && CP_REQ.instr[15:12] == PC_REG)
      |-> (CP_REQ.wdata == addr_q + 32'h0000000C))
    else $error("Source pc value is not address plus twelve.");
  a_mrc_extra_int: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_q == CRT_BUSY && !cp_reject && !CP_ACK.busy && dir_from_cp) |=>
    (state_q == CRT_INT) ##1 (state_q == CRT_XFER))
    else $error("Move from coprocessor missed its extra internal cycle.");
  a_mcr_direct: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_q == CRT_BUSY && !cp_reject && !CP_ACK.busy && !dir_from_cp) |=>
    (state_q == CRT_XFER))
    else $error("Move to coprocessor took an extra cycle.");
  a_und_cost: assert property (@(posedge REF_CLK) disable iff (!NRST)
    ($rose(state_q == CRT_SEQ) && $past(state_q == CRT_IDLE)) |->
    (state_q == CRT_SEQ)[*2] ##1 s_und_tail)
    else $error("Undefined exception cost is not 2S+1I+1N.");
  a_reject_traps: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_q == CRT_BUSY && cp_reject) |=>
    (state_q == CRT_SEQ && !CP_REQ.offer) ##1 s_und_tail)
    else $error("Rejected instruction did not trap.");
  a_und_flag: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (state_q == CRT_UND_N) |=> und_q && irq_st_q[IRQ_UND])
    else $error("Undefined exception not flagged.");

endmodule

// ---- pkg/crt_pkg.sv ----
// Package for the coprocessor register-transfer decoder: fields, offsets, counts and types.
package crt_pkg;

  // Instruction field positions.
  localparam int COND_HI     = 31;
  localparam int COND_LO     = 28;
  localparam int DIR_BIT     = 20;
  localparam int CPNUM_HI    = 11;
  localparam int CPNUM_LO    = 8;
  localparam int RD_HI       = 15;
  localparam int RD_LO       = 12;
  localparam int FLAG_N_BIT  = 31;
  localparam int FLAG_V_BIT  = 28;

  // Class signatures: bits 27:24 = 1110 with bit 4 = 1 is a register transfer.
  localparam logic [3:0]  RT_CLASS   = 4'hE;
  localparam logic [2:0]  UND_CLASS  = 3'h3;
  localparam logic [3:0]  PC_REG     = 4'hF;
  localparam logic [31:0] PC_OFFSET  = 32'h0000000C;
  localparam logic [3:0]  COND_AL    = 4'hE;

  // Cycle costs of each step.
  localparam logic [3:0] UND_S_CYC = 4'h2;
  localparam logic [3:0] UND_I_CYC = 4'h1;
  localparam logic [3:0] UND_N_CYC = 4'h1;

  // AXI4-Lite register offsets.
  localparam logic [7:0] OFF_INSTR   = 8'h00;
  localparam logic [7:0] OFF_ADDR    = 8'h04;
  localparam logic [7:0] OFF_CORE    = 8'h08;
  localparam logic [7:0] OFF_FLAGS   = 8'h0C;
  localparam logic [7:0] OFF_RESULT  = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;
  localparam logic [7:0] OFF_CYCLES  = 8'h20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt status bit positions.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UND  = 1;
  localparam int IRQ_SKIP = 2;
  localparam int IRQ_W    = 3;

  typedef enum logic [2:0] {CRT_IDLE, CRT_SEQ, CRT_BUSY, CRT_INT, CRT_XFER,
                            CRT_UND_I, CRT_UND_N} crt_state_t;

  // Coprocessor handshake as the core drives it.
  typedef struct packed {
    logic        offer;
    logic [31:0] instr;
    logic [31:0] wdata;
  } crt_cp_req_t;

  // Coprocessor acknowledge lines.
  typedef struct packed {
    logic        absent;
    logic        busy;
    logic [31:0] rdata;
  } crt_cp_ack_t;

endpackage

// ---- tb/crt_cp_model.sv ----
// Behavioural coprocessor that answers the core's register-transfer handshake.
`timescale 1ns/10ps
module crt_cp_model
  import crt_pkg::*;
#(
  parameter logic [3:0] CP_NUM = 4'h5
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire crt_cp_req_t req,
  output crt_cp_ack_t      ack,
  input  wire logic [3:0]  busy_cycles,
  input  wire logic [31:0] rd_val,
  output logic [31:0]      wr_seen
);
  logic [3:0] cnt_q;
  logic       hit;
  logic       und;

  // Only a transfer carrying our number is claimed; opcode and register fields are ours alone.
  assign hit = req.offer && req.instr[27:24] == RT_CLASS && req.instr[4]
               && req.instr[CPNUM_HI:CPNUM_LO] == CP_NUM;
  assign und = req.offer && req.instr[27:25] == UND_CLASS && req.instr[4];
  // Undefined encodings are refused with both lines high; idle data is inverted, not held.
  assign ack.absent = !hit || und;
  assign ack.busy   = und || (hit && cnt_q < busy_cycles);
  assign ack.rdata  = hit ? rd_val : ~rd_val;

  // Busy-wait counter and capture of the word moved towards the coprocessor.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= 4'h0;
      wr_seen <= 32'h0;
    end else begin
      cnt_q <= req.offer ? cnt_q + 4'h1 : 4'h0;
      if (hit && !req.instr[DIR_BIT]) wr_seen <= req.wdata;
    end
  end
endmodule

// ---- tb/crt_decode_bench.sv ----
// Self-checking bench for the register-transfer decoder with a coprocessor model.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module crt_decode_bench;
  import crt_pkg::*;
  logic        clk;
  logic        nrst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  crt_cp_req_t cp_req;
  crt_cp_ack_t cp_ack;
  logic        irq;
  logic [3:0]  busy_n;
  logic [31:0] rd_v;
  logic [31:0] wr_seen;
  int          error_cnt = 0;
  int          checks_done = 0;

  crt_decode #(.CP_FITTED(1'b1)) DUT (
    .REF_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CP_REQ(cp_req), .CP_ACK(cp_ack), .IRQ(irq));

  crt_cp_model #(.CP_NUM(4'h5)) cp (
    .clk(clk), .nrst(nrst), .req(cp_req), .ack(cp_ack),
    .busy_cycles(busy_n), .rd_val(rd_v), .wr_seen(wr_seen));

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // Writes hold each channel until its own ready is sampled, then wait for the response.
  // No bound of its own: only the watchdog ends a wait for the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Poll status until the busy bit drops; the bound keeps a stuck design from hanging here.
  task automatic wait_idle(output logic [31:0] v);
    logic [1:0] r;
    int n = 0;
    do begin
      rd(OFF_STATUS, v, r);
      n++;
    end while (v[0] !== 1'b0 && n < 200);
  endtask

  // Issue one instruction, then compare status and the incremental cycle count.
  task automatic exec(input logic [31:0] ins, input logic [3:0] b, input logic [31:0] d,
                      input logic [2:0] st, input logic [31:0] cyc);
    logic [31:0] v;
    logic [1:0]  r;
    busy_n <= b;
    rd_v <= d;
    wr(OFF_INSTR, ins, r);
    `CHK("instr resp", RESP_OKAY, r)
    wait_idle(v);
    `CHK("status", st, v[2:0])
    rd(OFF_CYCLES, v, r);
    `CHK("cycles", cyc, v)
  endtask

  function automatic logic [31:0] mk(logic [3:0] c, logic l, logic [3:0] rdn, logic [3:0] cp);
    return {c, RT_CLASS, 3'h1, l, 4'h2, rdn, cp, 3'h0, 1'b1, 4'h3};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized well beyond the expected few hundred cycles of the sequence.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  // Main sequence.
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    clk = 1'b0;
    nrst <= 1'b0; awaddr <= 8'h00; awvalid <= 1'b0; wdata <= 32'h0; wvalid <= 1'b0;
    bready <= 1'b0; araddr <= 8'h00; arvalid <= 1'b0; rready <= 1'b0;
    busy_n <= 4'h0; rd_v <= 32'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(OFF_STATUS, v, r);
    `CHK("status reset", 32'h0, v)
    rd(8'h40, v, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, v)
    wr(OFF_FLAGS, 32'h0, r);
    exec(mk(4'h0, 1'b1, 4'h3, 4'h5), 4'h0, 32'h0, 3'h4, 32'h0);
    rd(OFF_IRQ_ST, v, r);
    `CHK("irq status", 32'h4, v)
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_IRQ_MSK, 32'h7, r);
    repeat (2) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    wr(OFF_IRQ_ST, 32'h7, r);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    exec(mk(COND_AL, 1'b1, 4'h3, 4'h5), 4'h2, 32'hA5A51234, 3'h0, 32'h5);
    rd(OFF_RESULT, v, r);
    `CHK("result", 32'hA5A51234, v)
    exec(mk(COND_AL, 1'b1, PC_REG, 4'h5), 4'h0, 32'h9000FFFF, 3'h0, 32'h3);
    rd(OFF_FLAGS, v, r);
    `CHK("flags", 32'h9, v)
    rd(OFF_RESULT, v, r);
    `CHK("result kept", 32'hA5A51234, v)
    wr(OFF_ADDR, 32'h100, r);
    exec(mk(COND_AL, 1'b0, PC_REG, 4'h5), 4'h0, 32'h0, 3'h0, 32'h2);
    `CHK("pc store", 32'h10C, wr_seen)
    wr(OFF_CORE, 32'hDEADBEEF, r);
    exec(mk(COND_AL, 1'b0, 4'h4, 4'h5), 4'h3, 32'h0, 3'h0, 32'h5);
    `CHK("core store", 32'hDEADBEEF, wr_seen)
    exec(mk(COND_AL, 1'b1, 4'h3, 4'h6), 4'h0, 32'h0, 3'h2, 32'h4);
    exec({COND_AL, UND_CLASS, 20'h0, 1'b1, 4'h0}, 4'h0, 32'h0, 3'h2, 32'h4);
    exec({COND_AL, RT_CLASS, 19'h0, 1'b0, 4'h0}, 4'h0, 32'h0, 3'h2, 32'h4);
    exec(32'hE1A00000, 4'h0, 32'h0, 3'h0, 32'h0);
    rd(OFF_IRQ_ST, v, r);
    `CHK("irq events", 32'h3, v)
    busy_n <= 4'h8;
    wr(OFF_INSTR, mk(COND_AL, 1'b0, 4'h4, 4'h5), r);
    wr(OFF_ADDR, 32'h200, r);
    `CHK("busy write", RESP_SLVERR, r)
    wait_idle(v);
    rd(OFF_ADDR, v, r);
    `CHK("addr kept", 32'h100, v)
    end_sim();
  end
endmodule
